// *** core/dstel_baud.sv ***
`timescale 1ns/1ps
`default_nettype none
module dstel_baud (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Control
   input wire logic restart,
   input wire logic half_first,
   input wire logic [15:0] div,
   // Bit-period enable
   output logic tick
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic tick_next;

   // Restart aligns the phase; half_first lands ticks mid-bit for the receiver
   assign cnt_next = restart ? (half_first ? (div >> 1) : div - 16'h0001) :
                     (cnt_reg == 16'h0000) ? div - 16'h0001 : cnt_reg - 16'h0001;
   assign tick_next = !restart && (cnt_reg == 16'h0000);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick <= tick_next;
      end
   end
endmodule
`default_nettype wire

// *** core/dstel_fifo2.sv ***
`timescale 1ns/1ps
`default_nettype none
module dstel_fifo2 #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [DEPTH-1:0] vld_reg;
   logic pop;
   logic push;

   initial begin
      if (DEPTH < 2 || WIDTH < 1) $error("dstel_fifo2: bad size");
   end

   // Slot 0 is always the head, so the output is a plain flop
   assign pop = vld_reg[0] && out_ready;
   assign push = in_valid && in_ready;
   assign in_ready = !vld_reg[DEPTH-1];
   assign out_valid = vld_reg[0];
   assign out_data = mem_reg[0];

   // Shift on pop, then write the new word into the first free slot
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         vld_reg <= '0;
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            logic v;
            logic [WIDTH-1:0] d;
            v = pop ? ((i < DEPTH - 1) ? vld_reg[(i + 1) % DEPTH] : 1'b0) : vld_reg[i];
            d = pop ? mem_reg[(i + 1) % DEPTH] : mem_reg[i];
            if (push && !v && (i == 0 || (pop ? vld_reg[i] : vld_reg[i - 1]))) begin
               v = 1'b1;
               d = in_data;
            end
            vld_reg[i] <= v;
            mem_reg[i] <= d;
         end
      end
   end
endmodule
`default_nettype wire

// *** core/dstel_pkg.sv ***
package dstel_pkg;
   // System clock and the documented bit-rate range
   localparam int CLK_HZ = 40_000_000;
   localparam int BAUD_MIN = 2400;
   localparam int BAUD_MAX = 115200;
   localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BAUD_MIN);
   localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_MAX);
   // Character framing: start, 8 data, parity, stop
   localparam int CHAR_BITS = 11;
   localparam logic [3:0] LAST_BIT = 4'(CHAR_BITS - 1);
   localparam logic [3:0] PAR_BIT = 4'h9;
   // Telegram framing
   localparam logic [7:0] STX_CHAR = 8'h02;
   localparam int ADR_FMT_BIT = 7;
   localparam logic [6:0] ADR_BCAST = 7'h00;
   localparam logic [6:0] ADR_MIN = 7'h01;
   localparam logic [6:0] ADR_MAX = 7'h7e;
   localparam logic [7:0] LEN_OVERHEAD = 8'h02;
   localparam logic [7:0] LEN_SHORT = 8'h06;
   localparam logic [7:0] LEN_LONG = 8'h0e;
   localparam logic [8:0] IDX_LEN = 9'h001;
   localparam logic [8:0] IDX_ADR = 9'h002;
   // Parser and responder states
   typedef enum logic [2:0] {
      ST_HUNT, ST_LEN, ST_ADR, ST_DATA, ST_CHK, ST_WAIT, ST_SEND
   } dstel_state_t;
   // One received data byte with an end-of-telegram mark
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } dstel_byte_t;
endpackage

// *** core/dstel_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - Characters are start, eight data, parity and stop: eleven bit periods.
// - Parity makes data plus parity hold an even count of ones; one stop.
// - Telegram opens with 02 hex, then length byte, then address byte.
// - Variable count of data bytes follows the address byte.
// - One check byte closes the telegram after the last data byte.
// - One master, at most 126 slaves; mastership never moves.
// - Drive never transmits unprompted; it only answers a request to it.
// - No slave-to-slave traffic; every telegram passes between the master and a slave.
// - Half duplex: drive drives the pair only while sending a response.
// - Short format of eight bytes carries process data.
// - Long format of sixteen bytes adds a parameter channel.
// - A variable-length format carries text strings.
// - Node address configurable, valid values 1 to 126.
// - Bit rate configurable from 2400 to 115200 baud.
// - Wait at least the minimum response delay before answering.
// - Drop a partial telegram when the byte gap exceeds the limit.
// - Control word carries start, stops, reset, speeds, reverse, set-up, relays.
// - Length byte is data count plus address plus check byte.
// - Check byte is XOR of telegram bytes, starting from zero.
// - Address bit 7 set, bits 0-6 address, zero meaning broadcast.
// - Response returns the received address byte unchanged.
module dstel_slave (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Bus pair, driver enable high while driving
   input wire logic bus_rx,
   output logic bus_tx,
   output logic bus_tx_oe,
   // Configuration
   input wire logic [6:0] node_address,
   input wire logic [15:0] baud_div,
   input wire logic [15:0] min_resp_bits,
   input wire logic [15:0] max_ichar_bits,
   // Received data field stream
   output logic rx_valid,
   input wire logic rx_ready,
   output dstel_pkg::dstel_byte_t rx_byte,
   // Response data field stream
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   // Status
   output logic tel_ok,
   output logic tel_err,
   output logic cfg_bad,
   output logic responding
);
   dstel_pkg::dstel_state_t state_reg;
   dstel_pkg::dstel_state_t state_next;
   logic rx_busy_reg, rx_prev_reg, rx_done_reg, rx_perr_reg, rx_ferr_reg;
   logic [3:0] rx_cnt_reg;
   logic [9:0] rx_sh_reg;
   logic [7:0] rx_char_reg;
   logic [7:0] len_reg, adr_reg, chk_reg;
   logic [8:0] cnt_reg, idx_reg;
   logic bad_reg, hit_reg;
   logic [15:0] gap_cyc_reg, gap_bits_reg, tx_cyc_reg;
   logic tx_busy_reg, tx_ready_reg, bus_tx_reg, bus_oe_reg;
   logic [3:0] tx_cnt_reg;
   logic [9:0] tx_sh_reg;
   logic tel_ok_reg, tel_err_reg, cfg_bad_reg;
   logic rx_tick, tx_tick, rx_start, fifo_ready, fifo_push;
   logic adr_ok, addr_cfg_ok, baud_ok, timeout, tel_good;
   logic is_data, load, send_done;
   logic [7:0] tx_byte;

   // Even parity over the data byte
   function automatic logic par_even(input logic [7:0] d);
      return ^d;
   endfunction

   dstel_baud u_rx_baud (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .restart(rx_start),
      .half_first(1'b1),
      .div(baud_div),
      .tick(rx_tick)
   );

   dstel_baud u_tx_baud (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .restart(load),
      .half_first(1'b0),
      .div(baud_div),
      .tick(tx_tick)
   );

   // Two entries absorb a short stall by the consumer; beyond that the byte is lost
   dstel_fifo2 #(.WIDTH(9), .DEPTH(2)) u_buf (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .in_valid(fifo_push),
      .in_ready(fifo_ready),
      .in_data({rx_char_reg, cnt_reg == 9'h001}),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_byte)
   );

   // Configuration checks
   assign baud_ok = baud_div >= dstel_pkg::DIV_MIN && baud_div <= dstel_pkg::DIV_MAX;
   assign addr_cfg_ok = node_address >= dstel_pkg::ADR_MIN &&
                        node_address <= dstel_pkg::ADR_MAX;

   // Receiver ignores the pair while our own driver is on
   assign rx_start = !rx_busy_reg && rx_prev_reg && !bus_rx && !bus_oe_reg && baud_ok;

   // Receive character: sample mid-bit, check parity and stop
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_prev_reg <= 1'b1;
         rx_busy_reg <= 1'b0;
         rx_cnt_reg <= 4'h0;
         rx_sh_reg <= 10'h000;
         rx_done_reg <= 1'b0;
         rx_perr_reg <= 1'b0;
         rx_ferr_reg <= 1'b0;
         rx_char_reg <= 8'h00;
      end else begin
         rx_prev_reg <= bus_rx;
         rx_done_reg <= 1'b0;
         if (rx_start) begin
            rx_busy_reg <= 1'b1;
            rx_cnt_reg <= 4'h0;
         end else if (rx_busy_reg && rx_tick) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            rx_sh_reg <= {bus_rx, rx_sh_reg[9:1]};
            if (rx_cnt_reg == 4'h0 && bus_rx) begin
               rx_busy_reg <= 1'b0; // Glitch, not a start bit
            end else if (rx_cnt_reg == dstel_pkg::LAST_BIT) begin
               rx_busy_reg <= 1'b0;
               rx_done_reg <= 1'b1;
               rx_char_reg <= rx_sh_reg[8:1];
               rx_perr_reg <= par_even(rx_sh_reg[8:1]) != rx_sh_reg[9];
               rx_ferr_reg <= !bus_rx;
            end
         end
      end
   end

   // Idle gap measured in bit periods, held at zero while the line is busy
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gap_cyc_reg <= 16'h0000;
         gap_bits_reg <= 16'h0000;
      end else if (rx_busy_reg || rx_done_reg || bus_oe_reg) begin
         gap_cyc_reg <= 16'h0000;
         gap_bits_reg <= 16'h0000;
      end else if (gap_cyc_reg + 16'h0001 >= baud_div) begin
         gap_cyc_reg <= 16'h0000;
         if (gap_bits_reg != 16'hffff) gap_bits_reg <= gap_bits_reg + 16'h0001;
      end else begin
         gap_cyc_reg <= gap_cyc_reg + 16'h0001;
      end
   end

   // Parser decodes
   assign timeout = gap_bits_reg > max_ichar_bits && !rx_busy_reg;
   assign adr_ok = rx_char_reg[dstel_pkg::ADR_FMT_BIT] && addr_cfg_ok &&
                   (rx_char_reg[6:0] == node_address ||
                    rx_char_reg[6:0] == dstel_pkg::ADR_BCAST);
   assign tel_good = !bad_reg && !rx_perr_reg && !rx_ferr_reg &&
                     rx_char_reg == chk_reg;
   assign fifo_push = rx_done_reg && state_reg == dstel_pkg::ST_DATA && hit_reg;

   // Responder decodes: STX, length, address, data, check byte
   assign is_data = idx_reg > dstel_pkg::IDX_ADR && idx_reg <= {1'b0, len_reg};
   assign tx_byte = (idx_reg == 9'h000) ? dstel_pkg::STX_CHAR :
                    (idx_reg == dstel_pkg::IDX_LEN) ? len_reg :
                    (idx_reg == dstel_pkg::IDX_ADR) ? adr_reg :
                    is_data ? tx_data : chk_reg;
   assign load = state_reg == dstel_pkg::ST_SEND && !tx_busy_reg &&
                 idx_reg <= {1'b0, len_reg} + 9'h001 &&
                 (!is_data || (tx_valid && tx_ready_reg));
   assign send_done = state_reg == dstel_pkg::ST_SEND && !tx_busy_reg && !load &&
                      idx_reg == {1'b0, len_reg} + 9'h002;

   // Next state of the telegram sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         dstel_pkg::ST_HUNT: begin
            if (rx_done_reg && rx_char_reg == dstel_pkg::STX_CHAR &&
                !rx_perr_reg && !rx_ferr_reg) state_next = dstel_pkg::ST_LEN;
         end
         dstel_pkg::ST_LEN, dstel_pkg::ST_ADR, dstel_pkg::ST_DATA, dstel_pkg::ST_CHK: begin
            if (timeout) begin
               state_next = dstel_pkg::ST_HUNT;
            end else if (rx_done_reg) begin
               if (state_reg == dstel_pkg::ST_LEN)
                  state_next = rx_char_reg < dstel_pkg::LEN_OVERHEAD ?
                               dstel_pkg::ST_HUNT : dstel_pkg::ST_ADR;
               else if (state_reg == dstel_pkg::ST_ADR)
                  state_next = cnt_reg == 9'h000 ? dstel_pkg::ST_CHK : dstel_pkg::ST_DATA;
               else if (state_reg == dstel_pkg::ST_DATA)
                  state_next = cnt_reg == 9'h001 ? dstel_pkg::ST_CHK : dstel_pkg::ST_DATA;
               else
                  state_next = (tel_good && hit_reg && adr_reg[6:0] != dstel_pkg::ADR_BCAST) ?
                               dstel_pkg::ST_WAIT : dstel_pkg::ST_HUNT;
            end
         end
         dstel_pkg::ST_WAIT: begin
            if (gap_bits_reg >= min_resp_bits) state_next = dstel_pkg::ST_SEND;
         end
         dstel_pkg::ST_SEND: begin
            if (send_done) state_next = dstel_pkg::ST_HUNT;
         end
      endcase
   end

   // Telegram fields, running check byte and error accumulation
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= dstel_pkg::ST_HUNT;
         len_reg <= 8'h00;
         adr_reg <= 8'h00;
         chk_reg <= 8'h00;
         cnt_reg <= 9'h000;
         idx_reg <= 9'h000;
         bad_reg <= 1'b0;
         hit_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (rx_done_reg && state_reg != dstel_pkg::ST_WAIT &&
             state_reg != dstel_pkg::ST_SEND) begin
            chk_reg <= (state_reg == dstel_pkg::ST_HUNT) ? rx_char_reg :
                       chk_reg ^ rx_char_reg;
            if (rx_perr_reg || rx_ferr_reg) bad_reg <= 1'b1;
            if (state_reg == dstel_pkg::ST_HUNT) bad_reg <= 1'b0;
            if (state_reg == dstel_pkg::ST_LEN) begin
               len_reg <= rx_char_reg;
               cnt_reg <= {1'b0, rx_char_reg - dstel_pkg::LEN_OVERHEAD};
            end
            if (state_reg == dstel_pkg::ST_ADR) begin
               adr_reg <= rx_char_reg;
               hit_reg <= adr_ok;
            end
            if (state_reg == dstel_pkg::ST_DATA) begin
               cnt_reg <= cnt_reg - 9'h001;
               if (hit_reg && !fifo_ready) bad_reg <= 1'b1; // Overrun drops the telegram
            end
         end
         if (state_reg != dstel_pkg::ST_WAIT && state_next == dstel_pkg::ST_WAIT) begin
            chk_reg <= 8'h00;
            idx_reg <= 9'h000;
         end
         if (load) begin
            chk_reg <= chk_reg ^ tx_byte;
            idx_reg <= idx_reg + 9'h001;
         end
      end
   end

   // Transmit character: start bit at once, then ten more bit periods
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tx_busy_reg <= 1'b0;
         tx_cnt_reg <= 4'h0;
         tx_sh_reg <= 10'h3ff;
         tx_cyc_reg <= 16'h0000;
         bus_tx_reg <= 1'b1;
      end else if (load) begin
         tx_busy_reg <= 1'b1;
         tx_cnt_reg <= 4'h0;
         tx_sh_reg <= {1'b1, par_even(tx_byte), tx_byte};
         tx_cyc_reg <= 16'h0000;
         bus_tx_reg <= 1'b0;
      end else if (tx_busy_reg) begin
         tx_cyc_reg <= tx_cyc_reg + 16'h0001;
         if (tx_tick) begin
            if (tx_cnt_reg == dstel_pkg::LAST_BIT) begin // Stop bit has run a full period
               tx_busy_reg <= 1'b0;
               bus_tx_reg <= 1'b1;
            end else begin
               bus_tx_reg <= tx_sh_reg[0];
               tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
               tx_cnt_reg <= tx_cnt_reg + 4'h1;
            end
         end
      end
   end

   // Driver enable and response handshake; enable spans the whole response only
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bus_oe_reg <= 1'b0;
         tx_ready_reg <= 1'b0;
         tel_ok_reg <= 1'b0;
         tel_err_reg <= 1'b0;
         cfg_bad_reg <= 1'b0;
      end else begin
         bus_oe_reg <= state_next == dstel_pkg::ST_SEND;
         tx_ready_reg <= state_reg == dstel_pkg::ST_SEND && !tx_busy_reg &&
                         is_data && !load;
         tel_ok_reg <= state_reg == dstel_pkg::ST_CHK && rx_done_reg && !timeout &&
                       tel_good && hit_reg;
         tel_err_reg <= (state_reg == dstel_pkg::ST_CHK && rx_done_reg && !timeout &&
                         !tel_good) || (timeout && state_reg != dstel_pkg::ST_HUNT &&
                         state_reg != dstel_pkg::ST_WAIT && state_reg != dstel_pkg::ST_SEND);
         cfg_bad_reg <= !baud_ok || !addr_cfg_ok;
      end
   end

   assign bus_tx = bus_tx_reg;
   assign bus_tx_oe = bus_oe_reg;
   assign tx_ready = tx_ready_reg;
   assign tel_ok = tel_ok_reg;
   assign tel_err = tel_err_reg;
   assign cfg_bad = cfg_bad_reg;
   assign responding = bus_oe_reg;

   // Checks
   oe_only_send_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !bus_tx_oe |-> !tx_busy_reg && bus_tx_reg) else $error("driver off while sending");
   send_after_wait_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(state_reg == dstel_pkg::ST_SEND) |-> $past(state_reg) == dstel_pkg::ST_WAIT)
      else $error("response without request");
   min_delay_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(state_reg == dstel_pkg::ST_SEND) |-> $past(gap_bits_reg) >= $past(min_resp_bits))
      else $error("response too early");
   start_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      load |=> !bus_tx_reg && tx_busy_reg) else $error("no start bit");
   char_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      tx_busy_reg && tx_tick && tx_cnt_reg == dstel_pkg::LAST_BIT |->
      tx_cyc_reg == 16'(dstel_pkg::CHAR_BITS * baud_div))
      else $error("character not eleven bits long");
   tx_parity_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      load |=> tx_sh_reg[8] == ^tx_sh_reg[7:0] && tx_sh_reg[9]) else $error("bad parity");
   addr_echo_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      load && idx_reg == dstel_pkg::IDX_ADR |=> tx_sh_reg[7:0] == adr_reg)
      else $error("address not echoed");
   ichar_drop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      timeout && state_reg inside {dstel_pkg::ST_LEN, dstel_pkg::ST_ADR, dstel_pkg::ST_DATA,
      dstel_pkg::ST_CHK} |=> state_reg == dstel_pkg::ST_HUNT && tel_err_reg)
      else $error("timeout ignored");
   bad_check_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      rx_done_reg && state_reg == dstel_pkg::ST_CHK && rx_char_reg != chk_reg
      |=> !tel_ok_reg && state_reg == dstel_pkg::ST_HUNT) else $error("bad check accepted");
endmodule
`default_nettype wire

// *** verification/drive_serial_telegram_slave_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module drive_serial_telegram_slave_tb;
   localparam logic [15:0] DIV = 16'h015b; // Fastest rate keeps the run short
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic bus_rx, bus_tx, bus_tx_oe, rx_valid, tx_ready, tel_ok, tel_err, cfg_bad, responding;
   logic rx_ready = 1'b0;
   logic tx_valid = 1'b0;
   logic [1:0] rdy_mode = 2'b01;
   logic [6:0] node_address = 7'h05;
   logic [15:0] baud_div = DIV;
   logic [15:0] min_resp_bits = 16'h0003;
   logic [15:0] max_ichar_bits = 16'h0004;
   logic [7:0] tx_data, chk;
   logic [7:0] rsp_d[4];
   logic [7:0] tel[$];
   logic [7:0] exp[$];
   dstel_pkg::dstel_byte_t rx_byte;
   dstel_pkg::dstel_byte_t got_q[$];
   int fails = 0, check_count = 0, ok_n = 0, err_n = 0, oe_n = 0, tx_i = 0, gap, oe_ref;
   logic [6:0] ca[7] = '{7'h00, 7'h7f, 7'h7e, 7'h01, 7'h05, 7'h05, 7'h05};
   logic [15:0] cd[7] = '{DIV, DIV, DIV, DIV, DIV - 16'h0001, 16'h411a, 16'h411b};
   logic ce[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   always #12.5 sys_clk = ~sys_clk;
   assign tx_data = rsp_d[tx_i[1:0]];
   dstel_slave dut_u (.sys_clk(sys_clk), .resetn(resetn), .bus_rx(bus_rx), .bus_tx(bus_tx),
      .bus_tx_oe(bus_tx_oe), .node_address(node_address), .baud_div(baud_div),
      .min_resp_bits(min_resp_bits), .max_ichar_bits(max_ichar_bits), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tel_ok(tel_ok), .tel_err(tel_err), .cfg_bad(cfg_bad),
      .responding(responding));
   dstel_master_model master_u (.sys_clk(sys_clk), .div(baud_div), .bus_tx(bus_tx),
      .bus_tx_oe(bus_tx_oe), .bus_rx(bus_rx));
   // Event counts, receive capture and response feed; random stalls on demand
   always @(posedge sys_clk) begin
      if (tel_ok === 1'b1) ok_n++;
      if (tel_err === 1'b1) err_n++;
      if (bus_tx_oe === 1'b1) oe_n++;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back(rx_byte);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) tx_i <= tx_i + 1;
      rx_ready <= rdy_mode[1] ? 1'($urandom) : rdy_mode[0];
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [10:0] frame(input logic [7:0] b);
      return {1'b1, ^b, b, 1'b0};
   endfunction
   // Master builds a request; a bad check or a cut-off tail tests the drop paths
   task automatic send_tel(input logic [7:0] adr, input int n, input bit bad, input bit cut);
      logic [7:0] c;
      tel = {dstel_pkg::STX_CHAR, 8'(n + 2), adr};
      for (int i = 0; i < n; i++) tel.push_back(8'($urandom));
      c = 8'h00;
      foreach (tel[i]) c ^= tel[i];
      tel.push_back(c ^ {7'h00, bad});
      if (cut) tel = tel[0:1];
      foreach (tel[i]) master_u.send_char(tel[i]);
   endtask
   task automatic idle(input int bits);
      repeat (bits * DIV) @(posedge sys_clk);
   endtask
   // Watchdog sized from the telegram count
   initial begin
      repeat (150000) @(posedge sys_clk);
      fails++;
      $display("watchdog expired");
      results();
   end
   initial begin
      void'($urandom(19255));
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check("oe idle", bus_tx_oe, 0);
      check("tx idle", bus_tx, 1);
      for (int i = 0; i < 7; i++) begin
         node_address <= ca[i];
         baud_div <= cd[i];
         repeat (4) @(posedge sys_clk);
         check("cfg_bad", cfg_bad, ce[i]);
      end
      node_address <= 7'(1 + $urandom % 126);
      baud_div <= DIV;
      repeat (8) @(posedge sys_clk);
      $display("config range done");
      // Short request to this node with random receive stalls
      foreach (rsp_d[i]) rsp_d[i] = 8'($urandom);
      tx_valid <= 1'b1;
      rdy_mode <= 2'b10;
      send_tel({1'b1, node_address}, 4, 0, 0);
      gap = 0;
      while (bus_tx_oe !== 1'b1 && gap < 20 * DIV) begin
         @(posedge sys_clk);
         gap++;
      end
      check("turnaround", gap >= (min_resp_bits - 1) * DIV, 1);
      check("turnaround", gap < 20 * DIV, 1);
      check("responding", responding, 1);
      // Wait for the driver to let go, bounded in case it never does
      gap = 0;
      while (bus_tx_oe === 1'b1 && gap < 100 * DIV) begin
         @(posedge sys_clk);
         gap++;
      end
      repeat (2) @(posedge sys_clk);
      check("responding", responding, 0);
      tx_valid <= 1'b0;
      rdy_mode <= 2'b01;
      exp = {8'h02, 8'h06, tel[2], rsp_d[0], rsp_d[1], rsp_d[2], rsp_d[3]};
      chk = 8'h00;
      foreach (exp[i]) chk ^= exp[i];
      exp.push_back(chk);
      check("rsp count", master_u.rsp_q.size(), 8);
      foreach (exp[i]) check("rsp char", master_u.rsp_q[i], frame(exp[i]));
      // Each character reloads a few cycles after its stop period ends
      check("oe span", oe_n >= 88 * DIV && oe_n <= 88 * DIV + 24, 1);
      check("rx count", got_q.size(), 4);
      foreach (got_q[i]) check("rx byte", got_q[i], {tel[i + 3], 1'(i == 3)});
      check("ok count", ok_n, 1);
      oe_ref = oe_n;
      $display("addressed request done");
      // Broadcast while the consumer stalls: third byte overflows the buffer
      rdy_mode <= 2'b00;
      send_tel(8'h80, 3, 0, 0);
      idle(2);
      check("err count", err_n, 1);
      rdy_mode <= 2'b01;
      repeat (10) @(posedge sys_clk);
      check("rx count", got_q.size(), 6);
      check("rx byte", got_q[4].data, tel[3]);
      check("rx byte", got_q[5].data, tel[4]);
      $display("broadcast stall done");
      send_tel({1'b1, node_address}, 0, 1, 0);
      idle(2);
      check("err count", err_n, 2);
      send_tel({1'b1, node_address + 7'h01}, 0, 0, 0);
      idle(2);
      check("ok count", ok_n, 1);
      send_tel({1'b1, node_address}, 2, 0, 1);
      idle(8);
      check("err count", err_n, 3);
      check("silent", oe_n, oe_ref);
      $display("drop cases done");
      results();
   end
endmodule
`default_nettype wire

// *** verification/dstel_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Bus master: sends request characters, decodes the drive's answer
module dstel_master_model (
   // Clock and bit period
   input wire logic sys_clk,
   input wire logic [15:0] div,
   // Line pair
   input wire logic bus_tx,
   input wire logic bus_tx_oe,
   output logic bus_rx
);
   logic line;
   logic [10:0] rf;
   logic [10:0] rsp_q[$];
   // Biased termination pulls the released pair high
   assign line = bus_tx_oe ? bus_tx : 1'b1;
   initial bus_rx = 1'b1;
   // Start, data LSB first, even parity, stop
   task automatic send_char(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         bus_rx <= f[i];
         repeat (div) @(posedge sys_clk);
      end
   endtask
   // Sample each answer character at mid-bit
   initial forever begin
      @(posedge sys_clk);
      if (!line) begin
         repeat (div / 2) @(posedge sys_clk);
         for (int i = 0; i < 11; i++) begin
            rf[i] = line;
            if (i < 10) repeat (div) @(posedge sys_clk);
         end
         rsp_q.push_back(rf);
      end
   end
endmodule
`default_nettype wire
